// >>> rtl/sarseq_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the converter sequencer. Definitions only; included by bare name.
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH

// APB byte offsets, one aligned word per register
`define SARSEQ_OFS_CTRL0 12'h000
`define SARSEQ_OFS_CTRL1 12'h004
`define SARSEQ_OFS_RESH 12'h008
`define SARSEQ_OFS_RESL 12'h00C
`define SARSEQ_OFS_STAT 12'h010

// First control register fields
`define SARSEQ_C0_EN 0
`define SARSEQ_C0_GO 1
`define SARSEQ_C0_CHS_LO 2
`define SARSEQ_C0_CHS_HI 6
// Second control register fields
`define SARSEQ_C1_PREF_LO 0
`define SARSEQ_C1_PREF_HI 1
`define SARSEQ_C1_NREF 2
`define SARSEQ_C1_CS_LO 4
`define SARSEQ_C1_CS_HI 6
`define SARSEQ_C1_JUST 7
// Status register fields
`define SARSEQ_ST_DONE 0
`define SARSEQ_ST_IRQEN 1

// Reset values
`define SARSEQ_RST_CTRL0 8'h00
`define SARSEQ_RST_CTRL1 8'h00
`define SARSEQ_RST_RES 8'h00

// Channel codes
`define SARSEQ_CH_FIXREF 5'h1F
`define SARSEQ_CH_DAC 5'h1E
`define SARSEQ_CH_TEMP 5'h1D
`define SARSEQ_CH_PIN_MAX 5'h0D

// Conversion timing: bits resolved and the whole length in half bit periods
`define SARSEQ_CONV_BITS 4'd10
`define SARSEQ_CONV_TAD_X2 5'd23
// Instruction cycle in system clocks, delay before an RC start
`define SARSEQ_INSTR_CYC 3'd4
// Half bit period minus one, in system clocks, per divided clock code
`define SARSEQ_HALF_DIV2 6'h00
`define SARSEQ_HALF_DIV8 6'h03
`define SARSEQ_HALF_DIV32 6'h0F
`define SARSEQ_HALF_DIV4 6'h01
`define SARSEQ_HALF_DIV16 6'h07
`define SARSEQ_HALF_DIV64 6'h1F
`endif

// >>> rtl/sarseq_clkdiv.v
// Conversion clock divider: half-period enable pulses for one bit period.
// Assumes the RC oscillator edge is already synchronised to pclk.
`include "sarseq_regs.vh"
module sarseq_clkdiv
(
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [2:0] clk_sel,
   input wire rc_tick,
   output wire half_tick
);
   reg [5:0] cnt_r;
   reg [5:0] half_lim;

   // Half a bit period minus one, in system clocks, per select code
   always @*
   begin
      case (clk_sel)
         3'b000: half_lim = `SARSEQ_HALF_DIV2;
         3'b001: half_lim = `SARSEQ_HALF_DIV8;
         3'b010: half_lim = `SARSEQ_HALF_DIV32;
         3'b100: half_lim = `SARSEQ_HALF_DIV4;
         3'b101: half_lim = `SARSEQ_HALF_DIV16;
         3'b110: half_lim = `SARSEQ_HALF_DIV64;
         default: half_lim = `SARSEQ_HALF_DIV2;
      endcase
   end

   // Counter restarts with each run so periods align to the start
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= 6'h00;
      else if (!run || cnt_r >= half_lim)
         cnt_r <= 6'h00;
      else
         cnt_r <= cnt_r + 6'h01;
   end

   // RC codes x11 take their edges from the oscillator instead
   assign half_tick = run &&
      ((clk_sel[1:0] == 2'b11) ? rc_tick : (cnt_r >= half_lim));
endmodule // sarseq_clkdiv

// >>> rtl/sarseq_sync.v
// Three-stage synchroniser for one asynchronous level.
// Output changes once stages two and three agree.
module sarseq_sync
(
   input wire pclk,
   input wire presetn,
   input wire d,
   output reg q
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   // First stage feeds only the second
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q <= s3_r;
      end
   end
endmodule // sarseq_sync

// >>> rtl/sarseq_top.v
// Sequencer for a 10-bit successive-approximation converter, APB slave.
// Assumes an analog core with comparator, a trigger pulse on pclk, and
// a sleep level from the core; the RC clock arrives as a pin.
// Notes on behaviour
// (RULE1) Converter idle until enable written; only enabled converter starts
// (RULE2) Writing one to the status bit launches a conversion
// (RULE3) Software should enable first, then start in a later write
// (RULE4) Completion clears status, sets done flag, loads result bytes
// (RULE5) Clearing status early stops; unconverted bits copy last bit
// (RULE6) Reset returns all registers, converter off, conversion dropped
// (RULE7) RC clock: start delayed by one extra instruction cycle
// (RULE8) Sleep, RC clock, irq enabled: completion wakes the device
// (RULE9) Sleep, RC clock, irq disabled: power down after, enable stays
// (RULE10) Sleep with non-RC clock aborts and powers down, enable stays
// (RULE11) Trigger pulse sets status bit, starts, clears 16-bit timer
// (RULE12) Software keeps timing valid for trigger-started conversions
// (RULE13) Software configures, waits acquisition, polls or waits, clears
// (RULE14) Channel codes route fixed reference, DAC, temperature, pins 0-13
// (RULE15) Status bit reads one while converting, zero otherwise
// (RULE16) Enable clear means converter off, drawing no current
// (RULE17) Justify set: right justified, high byte upper six zero
// (RULE18) Justify clear: left justified, low byte lower six zero
// (RULE19) Clock field selects divide 2,8,32,4,16,64 or RC oscillator
// (RULE20) Negative reference: external pin when set, ground when clear
// (RULE21) Positive reference: fixed 11, pin 10, supply 00, 01 reserved
// (RULE22) Control bit seven and second bit three read zero
// (RULE23) Full conversion takes eleven and a half bit periods
// (RULE24) Done flag set every conversion, held until software clears
// (RULE25) Bits resolved MSB first, one per bit period, via comparator
// (RULE26) Starts during a running conversion are ignored
//
// Added by the designer: register access over APB and the register offsets.
`include "sarseq_regs.vh"
module sarseq_top
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire rc_osc,
   input wire cmp_out,
   input wire trigger_pulse,
   input wire sleep_active,
   output reg [9:0] trial_code,
   output reg sample_hold,
   output reg analog_power,
   output reg [4:0] channel_select,
   output reg channel_valid,
   output reg [1:0] positive_ref_select,
   output reg negative_ref_select,
   output reg done_pulse,
   output reg wake_req,
   output reg timer_clear
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_CONV = 2'd2;

   reg [1:0] state_r;
   reg converter_enable_r;
   reg go_r;
   reg [4:0] chs_r;
   reg just_r;
   reg [2:0] clk_sel_r;
   reg nref_r;
   reg [1:0] pref_r;
   reg [7:0] resh_r;
   reg [7:0] resl_r;
   reg done_flag_r;
   reg irq_en_r;
   reg [9:0] sar_r;
   reg [4:0] half_cnt_r;
   reg [2:0] wait_cnt_r;
   reg last_bit_r;
   reg sleep_off_r;
   reg rc_prev_r;
   wire rc_sync;
   wire half_tick;
   wire rc_sel;
   wire wr_en;
   wire rd_en;
   wire wr_c0;
   wire sw_start;
   wire sw_stop;
   wire start_req;
   wire conv_end;
   wire [9:0] fill;
   wire [9:0] partial;
   reg [9:0] res_src;
   reg [7:0] rd_byte;

   assign rc_sel = (clk_sel_r[1:0] == 2'b11); // (RULE19)

   // RC oscillator arrives from its own domain
   sarseq_sync u_rc_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(rc_osc),
      .q(rc_sync)
   );

   // Half bit-period ticks for the selected conversion clock
   sarseq_clkdiv u_div
   (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_r == ST_CONV),
      .clk_sel(clk_sel_r),
      .rc_tick(rc_sync != rc_prev_r),
      .half_tick(half_tick)
   );

   // APB decode: zero wait states, so every access ends in one cycle
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign wr_c0 = wr_en && (paddr == `SARSEQ_OFS_CTRL0);
   assign sw_start = wr_c0 && pwdata[`SARSEQ_C0_GO] && converter_enable_r
      && !sleep_off_r; // (RULE1)
   assign sw_stop = wr_c0 && !pwdata[`SARSEQ_C0_GO];
   // Hardware trigger also only starts an enabled converter
   assign start_req = (sw_start || (trigger_pulse && converter_enable_r
      && !sleep_off_r)) && (state_r == ST_IDLE); // (RULE2) (RULE11) (RULE26)
   assign conv_end = (state_r == ST_CONV) && half_tick &&
      (half_cnt_r == `SARSEQ_CONV_TAD_X2 - 5'd1); // (RULE23)

   // Bits not yet decided copy the last one decided
   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1)
      begin : g_fill
         // Decided bits run from 9 down to 10 less the decisions made
         assign fill[g] = ((half_cnt_r >> 1) < 10 - g) ? 1'b1 : 1'b0;
         assign partial[g] = fill[g] ? last_bit_r : sar_r[g]; // (RULE5)
      end
   endgenerate

   // Result source: full on completion, patched when stopped early
   always @*
   begin
      res_src = conv_end ? sar_r : partial;
   end

   // Control registers, status bit and sequencing state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_IDLE; // (RULE6)
         converter_enable_r <= 1'b0;
         go_r <= 1'b0;
         chs_r <= 5'h00;
         just_r <= 1'b0;
         clk_sel_r <= 3'h0;
         nref_r <= 1'b0;
         pref_r <= 2'h0;
         resh_r <= `SARSEQ_RST_RES;
         resl_r <= `SARSEQ_RST_RES;
         done_flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         sar_r <= 10'h000;
         half_cnt_r <= 5'h00;
         wait_cnt_r <= 3'h0;
         last_bit_r <= 1'b0;
         sleep_off_r <= 1'b0;
         rc_prev_r <= 1'b0;
      end
      else
      begin
         rc_prev_r <= rc_sync;
         if (wr_c0)
         begin
            converter_enable_r <= pwdata[`SARSEQ_C0_EN];
            chs_r <= pwdata[`SARSEQ_C0_CHS_HI:`SARSEQ_C0_CHS_LO];
         end
         if (wr_en && paddr == `SARSEQ_OFS_CTRL1)
         begin
            just_r <= pwdata[`SARSEQ_C1_JUST];
            clk_sel_r <= pwdata[`SARSEQ_C1_CS_HI:`SARSEQ_C1_CS_LO];
            nref_r <= pwdata[`SARSEQ_C1_NREF];
            pref_r <= pwdata[`SARSEQ_C1_PREF_HI:`SARSEQ_C1_PREF_LO];
         end
         if (wr_en && paddr == `SARSEQ_OFS_STAT)
            irq_en_r <= pwdata[`SARSEQ_ST_IRQEN];
         // Power-down by sleep holds until sleep ends; enable untouched
         if (!sleep_active)
            sleep_off_r <= 1'b0;
         // Done flag: hardware set wins over a software clear
         if (conv_end)
            done_flag_r <= 1'b1; // (RULE24)
         else if (wr_en && paddr == `SARSEQ_OFS_STAT &&
            !pwdata[`SARSEQ_ST_DONE])
            done_flag_r <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (start_req)
               begin
                  go_r <= 1'b1; // (RULE15)
                  wait_cnt_r <= 3'h0;
                  sar_r <= 10'h200;
                  half_cnt_r <= 5'h00;
                  state_r <= rc_sel ? ST_WAIT : ST_CONV; // (RULE7)
               end
               // Result bytes are software writable when idle
               else if (wr_en && paddr == `SARSEQ_OFS_RESH)
                  resh_r <= pwdata[7:0];
               else if (wr_en && paddr == `SARSEQ_OFS_RESL)
                  resl_r <= pwdata[7:0];
            end
            ST_WAIT:
            begin
               // One instruction cycle lets a sleep instruction go first
               if (sw_stop || !converter_enable_r)
               begin
                  go_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (wait_cnt_r == `SARSEQ_INSTR_CYC - 3'd1)
                  state_r <= ST_CONV; // (RULE7)
               else
                  wait_cnt_r <= wait_cnt_r + 3'd1;
            end
            ST_CONV:
            begin
               if (half_tick)
                  half_cnt_r <= half_cnt_r + 5'd1;
               // Decide one bit per period, MSB first, on the odd half
               if (half_tick && half_cnt_r[0] &&
                  (half_cnt_r >> 1) < {1'b0, `SARSEQ_CONV_BITS})
               begin
                  sar_r <= trial_next(sar_r, cmp_out); // (RULE25)
                  last_bit_r <= cmp_out;
               end
               if (conv_end || sw_stop || !converter_enable_r ||
                  (sleep_active && !rc_sel))
               begin
                  go_r <= 1'b0; // (RULE4) (RULE5)
                  state_r <= ST_IDLE;
                  if (sleep_active && !rc_sel)
                     sleep_off_r <= 1'b1; // (RULE10)
                  else if (conv_end && sleep_active && !irq_en_r)
                     sleep_off_r <= 1'b1; // (RULE9)
                  // Reset of enable abandons without a result
                  if (conv_end || sw_stop)
                  begin
                     if (just_r)
                     begin
                        resh_r <= {6'h00, res_src[9:8]}; // (RULE17)
                        resl_r <= res_src[7:0];
                     end
                     else
                     begin
                        resh_r <= res_src[9:2]; // (RULE18)
                        resl_r <= {res_src[1:0], 6'h00};
                     end
                  end
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Apply the comparator decision and set the next trial bit
   function [9:0] trial_next;
      input [9:0] code;
      input dec;
      reg [9:0] low;
      reg [9:0] res;
      begin
         low = code & (~code + 10'h001); // Lowest set bit is the trial
         res = dec ? code : (code & ~low);
         res = res | (low >> 1);
         trial_next = res;
      end
   endfunction

   // Read mux; unimplemented bits read zero
   always @*
   begin
      case (paddr)
         `SARSEQ_OFS_CTRL0:
            rd_byte = {1'b0, chs_r, go_r, converter_enable_r}; // (RULE22)
         `SARSEQ_OFS_CTRL1:
            rd_byte = {just_r, clk_sel_r, 1'b0, nref_r, pref_r};
         `SARSEQ_OFS_RESH: rd_byte = resh_r;
         `SARSEQ_OFS_RESL: rd_byte = resl_r;
         `SARSEQ_OFS_STAT: rd_byte = {6'h00, irq_en_r, done_flag_r};
         default: rd_byte = 8'h00;
      endcase
   end

   // APB answer registered on the setup cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr[1:0] != 2'b00 ||
            paddr > `SARSEQ_OFS_STAT);
         if (rd_en)
            prdata <= {24'h00_0000, rd_byte};
      end
   end

   // Analog-side outputs, all registered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trial_code <= 10'h000;
         sample_hold <= 1'b0;
         analog_power <= 1'b0;
         channel_select <= 5'h00;
         channel_valid <= 1'b1; // Code zero routes pin zero
         positive_ref_select <= 2'h0;
         negative_ref_select <= 1'b0;
         done_pulse <= 1'b0;
         wake_req <= 1'b0;
         timer_clear <= 1'b0;
      end
      else
      begin
         trial_code <= sar_r;
         // Sample held while bits are decided
         sample_hold <= (state_r == ST_CONV);
         analog_power <= converter_enable_r && !sleep_off_r; // (RULE16)
         channel_select <= chs_r;
         channel_valid <= (chs_r <= `SARSEQ_CH_PIN_MAX) ||
            (chs_r == `SARSEQ_CH_FIXREF) || (chs_r == `SARSEQ_CH_DAC) ||
            (chs_r == `SARSEQ_CH_TEMP); // (RULE14)
         positive_ref_select <= pref_r; // (RULE21)
         negative_ref_select <= nref_r; // (RULE20)
         done_pulse <= conv_end;
         wake_req <= conv_end && sleep_active && rc_sel && irq_en_r; // (RULE8)
         timer_clear <= trigger_pulse; // (RULE11)
      end
   end
endmodule // sarseq_top

// >>> tb/sarseq_analog.sv
// Far-side model of the converter core: comparator and RC oscillator.
// Assumes the sequencer keeps a trial bit when the comparator says 1.
module sarseq_analog
(
   input wire logic [9:0] trial_code,
   input wire logic [9:0] vin,
   output logic cmp_out,
   output logic rc_osc
);
   timeunit 1ns;
   timeprecision 1ns;
   // Ideal comparator, so a full conversion must reproduce vin exactly
   assign cmp_out = (trial_code <= vin);
   // Free-running RC oscillator, 800 ns period, sixteen pclk periods
   initial
   begin
      rc_osc = 1'b0;
      forever #400 rc_osc = ~rc_osc;
   end
endmodule // sarseq_analog

// >>> tb/sarseq_checker.sv
// Concurrent checks on the sequencer top ports.
// Assumes one clock domain, pclk, with presetn as its reset.
module sarseq_checker
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire trigger_pulse,
   input wire sleep_active,
   input wire sample_hold,
   input wire analog_power,
   input wire [4:0] channel_select,
   input wire channel_valid,
   input wire done_pulse,
   input wire wake_req,
   input wire timer_clear
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   err_unmapped_a: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   timer_clear_a: assert property (trigger_pulse |=> timer_clear)
      else $error("timer not cleared after trigger");
   chan_valid_a: assert property (channel_valid ==
      (channel_select <= 5'h0D || channel_select >= 5'h1D))
      else $error("channel routing flag wrong");
   start_powered_a: assert property ($rose(sample_hold) |-> analog_power)
      else $error("sampling while unpowered");
   done_ends_a: assert property (done_pulse |-> ##[0:2] !sample_hold)
      else $error("still converting after done");
   wake_sleep_a: assert property (wake_req |-> sleep_active ||
      $past(sleep_active))
      else $error("wake request while awake");
   reset_idle_a: assert property ($rose(presetn) |->
      !sample_hold && !analog_power)
      else $error("converter active after reset");
endmodule // sarseq_checker

bind sarseq_top sarseq_checker chk_i (.*);

// >>> tb/sarseq_top_tb.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes sarseq_analog as the core and sarseq_checker bound to the top.
module sarseq_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, rc_osc, cmp_out, wake_seen = 0;
   logic trigger_pulse = 0, sleep_active = 0, j;
   logic [9:0] trial_code, vin = 0, r;
   logic [15:0] rw;
   logic [2:0] cs;
   logic sample_hold, analog_power, channel_valid, negative_ref_select;
   logic [4:0] channel_select;
   logic [1:0] positive_ref_select;
   logic done_pulse, wake_req, timer_clear;
   int n_fail = 0, total_checks = 0, seed = 46, cyc = 0, n_wait = 0;

   sarseq_top dut (.*);
   sarseq_analog ana (.*);

   // Clock, 50 ns period
   initial
   begin
      forever #25 pclk = ~pclk;
   end
   // Hang guard and sticky wake capture (wake is only a pulse)
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (wake_req === 1'b1)
         wake_seen <= 1'b1;
      if (cyc == 40000)
      begin
         n_fail++;
         test_done;
      end
   end

   task test_done;
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Result word as the two bytes should hold it
   function logic [15:0] exp_res(input logic [9:0] v, input logic jr);
      return jr ? {6'h00, v} : {v, 6'h00};
   endfunction

   // Partial result: top k bits converted, the rest copy bit 10-k
   function logic part_ok(input logic [9:0] rr, input logic [9:0] v);
      logic [9:0] m;
      for (int k = 1; k <= 10; k++)
      begin
         m = 10'h3FF << (10 - k);
         if (rr === ((v & m) | (v[10 - k] ? ~m : 10'h000)))
            return 1'b1;
      end
      return 1'b0;
   endfunction

   // Divisor that each divided clock code selects
   function int div_of(input logic [2:0] c);
      case (c)
         3'b000: return 2;
         3'b001: return 8;
         3'b010: return 32;
         3'b100: return 4;
         3'b101: return 16;
         default: return 64;
      endcase
   endfunction

   // Both result bytes as read; r is the value they carry
   task read_res(input logic jr);
      apb(0, 12'h008, 0);
      rw[15:8] = rd[7:0];
      apb(0, 12'h00C, 0);
      rw[7:0] = rd[7:0];
      r = jr ? rw[9:0] : rw[15:6];
   endtask

   // Cycles waited are kept for the timing check
   task wait_done;
      for (n_wait = 0; n_wait < 3000 && done_pulse !== 1'b1; n_wait++)
         @(posedge pclk);
      chk(done_pulse, 1, "done pulse");
   endtask

   // Enable in one write, start in the next
   task start(input logic [7:0] c1);
      apb(1, 12'h004, c1);
      apb(1, 12'h000, 1);
      apb(1, 12'h000, 3);
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      for (int a = 0; a <= 16; a += 4)
      begin
         apb(0, a[11:0], 0);
         chk(rd, 0, "reset value");
      end
      apb(0, 12'h014, 0);
      chk(err, 1, "unmapped error");
      apb(1, 12'h000, 32'h0000_00FC);
      apb(0, 12'h000, 0);
      chk(rd, 32'h0000_007C, "ctrl0 readback");
      apb(1, 12'h004, 32'h0000_00FF);
      apb(0, 12'h004, 0);
      chk(rd, 32'h0000_00F7, "ctrl1 readback");
      chk({negative_ref_select, positive_ref_select}, 7, "refs");
      for (int c = 0; c < 32; c++)
      begin
         apb(1, 12'h000, c << 2);
         repeat (2) @(posedge pclk);
         chk(channel_select, c, "channel");
         chk(channel_valid, c <= 13 || c >= 29, "routed");
      end
      apb(1, 12'h000, 2);
      apb(0, 12'h000, 0);
      chk(rd[1:0], 0, "start while off");
      // Random conversions at every divided clock, both justifications
      for (int i = 0; i < 6; i++)
      begin
         vin <= 10'($random(seed));
         j = i[0];
         cs = (i < 3) ? i[2:0] : i[2:0] + 3'd1;
         start({j, cs, 4'h0});
         apb(0, 12'h000, 0);
         chk(rd[1], 1, "busy");
         // A second start mid-run must not restart the cycle
         apb(1, 12'h000, 3);
         wait_done;
         // 23 half periods from the start edge plus one to see done, 6 spent on two bus calls
         chk(n_wait, 23 * div_of(cs) / 2 - 5, "conv time");
         apb(0, 12'h000, 0);
         chk(rd[1:0], 1, "go cleared");
         read_res(j);
         chk(rw, exp_res(vin, j), "result");
         chk(r, vin, "value");
         apb(0, 12'h010, 0);
         chk(rd[0], 1, "done flag");
         apb(1, 12'h010, 0);
      end
      apb(1, 12'h000, 0);
      repeat (2) @(posedge pclk);
      chk(analog_power, 0, "power off");
      // Early stop leaves a partial, filled result
      start(8'hE0);
      repeat (200) @(posedge pclk);
      apb(1, 12'h000, 1);
      apb(0, 12'h000, 0);
      chk(rd[1], 0, "stopped");
      read_res(1);
      chk(part_ok(r, vin), 1, "partial");
      // Hardware trigger starts a conversion
      vin <= 10'($random(seed));
      apb(1, 12'h004, 8'h80);
      @(posedge pclk);
      trigger_pulse <= 1;
      @(posedge pclk);
      trigger_pulse <= 0;
      wait_done;
      read_res(1);
      chk(r, vin, "trigger result");
      // Sleep with a divided clock aborts
      start(8'h60);
      repeat (50) @(posedge pclk);
      sleep_active <= 1;
      repeat (5) @(posedge pclk);
      chk(analog_power, 0, "sleep abort");
      apb(0, 12'h000, 0);
      chk(rd[0], 1, "enable kept");
      sleep_active <= 0;
      // RC clock in sleep, interrupt off then on
      for (int q = 0; q < 2; q++)
      begin
         vin <= 10'($random(seed));
         apb(1, 12'h010, q << 1);
         wake_seen <= 0;
         start(8'h30);
         sleep_active <= 1;
         wait_done;
         repeat (3) @(posedge pclk);
         chk(wake_seen, q, "wake");
         if (q == 0)
            chk(analog_power, 0, "rc power down");
         sleep_active <= 0;
         apb(0, 12'h000, 0);
         chk(rd[0], 1, "rc enable kept");
         read_res(0);
         chk(r, vin, "rc result");
      end
      // Reset in mid-conversion
      start(8'h60);
      repeat (20) @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h000, 0);
      chk(rd, 0, "reset mid run");
      chk(sample_hold, 0, "held after reset");
      test_done;
   end
endmodule // sarseq_top_tb
